// file: common/tei_hpd_if.sv
`timescale 1ns/1ns
interface tei_hpd_if;
   logic connect_ev;
   logic disconnect_ev;
   logic toggle_ev;
   logic level;
   modport src (output connect_ev, output disconnect_ev, output toggle_ev, output level);
   modport snk (input connect_ev, input disconnect_ev, input toggle_ev, input level);
endinterface : tei_hpd_if

// file: common/tei_pkg.sv
package tei_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned HPD_CONN_MS = 10;
   localparam int unsigned HPD_DISC_MS = 100;
   localparam int unsigned HPD_TGL_MIN_MS = 50;
   localparam int unsigned HPD_TGL_MAX_MS = 99;
   localparam int unsigned HPD_CONN_CYC = HPD_CONN_MS * (CLK_HZ / 1000);
   localparam int unsigned HPD_DISC_CYC = HPD_DISC_MS * (CLK_HZ / 1000);
   localparam int unsigned HPD_TGL_MIN_CYC = HPD_TGL_MIN_MS * (CLK_HZ / 1000);
   localparam int unsigned HPD_TGL_MAX_CYC = HPD_TGL_MAX_MS * (CLK_HZ / 1000);
   localparam int unsigned HPD_CNT_W = 22;
   localparam int unsigned EV_N = 10;
   typedef logic [EV_N-1:0] tei_ev_t;
   typedef logic [HPD_CNT_W-1:0] tei_cnt_t;
   // Pending flag positions
   localparam int unsigned EV_CONNECT = 0;
   localparam int unsigned EV_DISCONNECT = 1;
   localparam int unsigned EV_TOGGLE = 2;
   localparam int unsigned EV_LINK_UP = 3;
   localparam int unsigned EV_LINK_DOWN = 4;
   localparam int unsigned EV_FRAME_SYNC = 5;
   localparam int unsigned EV_BRIDGE_UNLOCK = 6;
   localparam int unsigned EV_CP14 = 7;
   localparam int unsigned EV_CP14_TIMER = 8;
   localparam int unsigned EV_CP23_TIMER = 9;
   localparam tei_ev_t PEND_RST = 10'h000;
   typedef enum logic [1:0] {
      TEI_HPD_IDLE = 2'b00,
      TEI_HPD_LOW = 2'b01,
      TEI_HPD_HIGH = 2'b10
   } tei_hpd_e;
endpackage : tei_pkg

// file: core/tei_hpd_det.sv
`timescale 1ns/1ns
module tei_hpd_det #(
   parameter tei_pkg::tei_cnt_t P_CONN_CYC = tei_pkg::tei_cnt_t'(tei_pkg::HPD_CONN_CYC),
   parameter tei_pkg::tei_cnt_t P_DISC_CYC = tei_pkg::tei_cnt_t'(tei_pkg::HPD_DISC_CYC),
   parameter tei_pkg::tei_cnt_t P_TGL_MIN_CYC = tei_pkg::tei_cnt_t'(tei_pkg::HPD_TGL_MIN_CYC),
   parameter tei_pkg::tei_cnt_t P_TGL_MAX_CYC = tei_pkg::tei_cnt_t'(tei_pkg::HPD_TGL_MAX_CYC)
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hot_plug_sense,
   tei_hpd_if.src o_ev
);
   import tei_pkg::*;

   tei_hpd_e state_r;
   tei_cnt_t cnt_r;
   logic disc_seen_r;
   logic conn_ev_r;
   logic disc_ev_r;
   logic tgl_ev_r;
   logic level_r;

   // State follows the line; first cycle after reset only records the level
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_r <= TEI_HPD_IDLE;
         level_r <= 1'b0;
      end else begin
         level_r <= i_hot_plug_sense;
         case (state_r)
            TEI_HPD_IDLE: state_r <= i_hot_plug_sense ? TEI_HPD_HIGH : TEI_HPD_LOW;
            TEI_HPD_LOW: if (i_hot_plug_sense) state_r <= TEI_HPD_HIGH;
            TEI_HPD_HIGH: if (!i_hot_plug_sense) state_r <= TEI_HPD_LOW;
            default: state_r <= TEI_HPD_IDLE;
         endcase
      end
   end

   // Cycles held at the present level, saturating so long holds never wrap
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_r <= '0;
      end else if (state_r == TEI_HPD_IDLE || i_hot_plug_sense != level_r) begin
         cnt_r <= tei_cnt_t'(1);
      end else if (cnt_r != '1) begin
         cnt_r <= cnt_r + tei_cnt_t'(1);
      end
   end

   // Events are single cycles; disconnect at a low hold's limit, connect at a high hold's limit after a disconnect, toggle when an in-range low pulse ends
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         conn_ev_r <= 1'b0;
         disc_ev_r <= 1'b0;
         tgl_ev_r <= 1'b0;
         disc_seen_r <= 1'b0;
      end else begin
         conn_ev_r <= 1'b0;
         disc_ev_r <= 1'b0;
         tgl_ev_r <= 1'b0;
         if (state_r == TEI_HPD_HIGH && level_r && i_hot_plug_sense && disc_seen_r
             && cnt_r == P_CONN_CYC) begin
            conn_ev_r <= 1'b1;
            disc_seen_r <= 1'b0;
         end
         if (state_r == TEI_HPD_LOW && !level_r && !i_hot_plug_sense && cnt_r == P_DISC_CYC) begin
            disc_ev_r <= 1'b1;
            disc_seen_r <= 1'b1;
         end
         // Low pulse ending: its width is the count held while low
         if (state_r == TEI_HPD_LOW && !level_r && i_hot_plug_sense
             && cnt_r >= P_TGL_MIN_CYC && cnt_r <= P_TGL_MAX_CYC) begin
            tgl_ev_r <= 1'b1;
         end
      end
   end

   assign o_ev.connect_ev = conn_ev_r;
   assign o_ev.disconnect_ev = disc_ev_r;
   assign o_ev.toggle_ev = tgl_ev_r;
   assign o_ev.level = level_r;
endmodule : tei_hpd_det

// file: core/tei_top.sv
`timescale 1ns/1ns
module tei_top #(
   parameter int unsigned P_HPD_CONN_CYC = tei_pkg::HPD_CONN_CYC,
   parameter int unsigned P_HPD_DISC_CYC = tei_pkg::HPD_DISC_CYC,
   parameter int unsigned P_HPD_TGL_MIN_CYC = tei_pkg::HPD_TGL_MIN_CYC,
   parameter int unsigned P_HPD_TGL_MAX_CYC = tei_pkg::HPD_TGL_MAX_CYC,
   parameter bit P_CP14_EN = 1'b1,
   parameter bit P_CP23_EN = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hot_plug_sense,
   input wire logic i_link_clk_stable,
   input wire logic i_vsync,
   input wire logic i_bridge_locked,
   input wire logic i_cp14_irq,
   input wire logic i_cp14_timer_irq,
   input wire logic i_cp23_timer_irq,
   input wire tei_pkg::tei_ev_t i_pend_clr,
   output logic [tei_pkg::EV_N-1:0] o_pending,
   output logic o_link_status,
   output logic o_hot_plug_level,
   output logic o_irq
);
   import tei_pkg::*;

   // Sources that exist only in a build carrying that protection engine
   localparam tei_ev_t BUILD_MASK = {P_CP23_EN, P_CP14_EN, P_CP14_EN, 7'h7F};

   tei_hpd_if hpd_ev ();

   tei_hpd_det #(
      .P_CONN_CYC(tei_cnt_t'(P_HPD_CONN_CYC)),
      .P_DISC_CYC(tei_cnt_t'(P_HPD_DISC_CYC)),
      .P_TGL_MIN_CYC(tei_cnt_t'(P_HPD_TGL_MIN_CYC)),
      .P_TGL_MAX_CYC(tei_cnt_t'(P_HPD_TGL_MAX_CYC))
   ) u_hpd (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_hot_plug_sense(i_hot_plug_sense),
      .o_ev(hpd_ev)
   );

   logic link_status_r;
   logic vsync_r;
   logic locked_r;
   logic cp14_r;
   logic cp14_tmr_r;
   logic cp23_tmr_r;
   tei_ev_t pend_r;
   tei_ev_t pend_nxt;
   tei_ev_t ev_set;
   logic irq_r;

   // Link status tracks the stable indication from the link clock monitor
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         link_status_r <= 1'b0;
      end else begin
         link_status_r <= i_link_clk_stable;
      end
   end

   // Previous samples for edge detection; lock starts high so a bridge unlocked out of reset flags an unlock
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         vsync_r <= 1'b0;
         locked_r <= 1'b1;
         cp14_r <= 1'b0;
         cp14_tmr_r <= 1'b0;
         cp23_tmr_r <= 1'b0;
      end else begin
         vsync_r <= i_vsync;
         locked_r <= i_bridge_locked;
         cp14_r <= i_cp14_irq;
         cp14_tmr_r <= i_cp14_timer_irq;
         cp23_tmr_r <= i_cp23_timer_irq;
      end
   end

   always_comb begin
      ev_set = '0;
      ev_set[EV_CONNECT] = hpd_ev.connect_ev;
      ev_set[EV_DISCONNECT] = hpd_ev.disconnect_ev;
      ev_set[EV_TOGGLE] = hpd_ev.toggle_ev;
      // Separate flags let software tell up from down on one source
      ev_set[EV_LINK_UP] = i_link_clk_stable && !link_status_r;
      ev_set[EV_LINK_DOWN] = !i_link_clk_stable && link_status_r;
      ev_set[EV_FRAME_SYNC] = i_vsync && !vsync_r;
      ev_set[EV_BRIDGE_UNLOCK] = !i_bridge_locked && locked_r;
      ev_set[EV_CP14] = i_cp14_irq && !cp14_r;
      ev_set[EV_CP14_TIMER] = i_cp14_timer_irq && !cp14_tmr_r;
      ev_set[EV_CP23_TIMER] = i_cp23_timer_irq && !cp23_tmr_r;
      ev_set = ev_set & BUILD_MASK;
      // A set in the clearing cycle wins so no event is lost
      pend_nxt = (pend_r & ~i_pend_clr) | ev_set;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pend_r <= PEND_RST;
         irq_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         irq_r <= |pend_nxt;
      end
   end

   assign o_pending = pend_r;
   assign o_link_status = link_status_r;
   assign o_hot_plug_level = hpd_ev.level;
   assign o_irq = irq_r;
endmodule : tei_top

// file: tb/tei_monitor.sv
`timescale 1ns/1ns
module tei_monitor #(
   parameter int unsigned P_HPD_DISC_CYC = tei_pkg::HPD_DISC_CYC,
   parameter bit P_CP14_EN = 1'b1,
   parameter bit P_CP23_EN = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hot_plug_sense,
   input wire logic i_link_clk_stable,
   input wire logic i_vsync,
   input wire logic i_bridge_locked,
   input wire logic i_cp14_irq,
   input wire logic i_cp23_timer_irq,
   input wire tei_pkg::tei_ev_t i_pend_clr,
   input wire logic [tei_pkg::EV_N-1:0] o_pending,
   input wire logic o_link_status,
   input wire logic o_hot_plug_level,
   input wire logic o_irq
);
   import tei_pkg::*;
   int unsigned lo_cnt_r;
   always_ff @(posedge i_clk) begin
      lo_cnt_r <= (i_sys_rst || i_hot_plug_sense) ? 0 : lo_cnt_r + 1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence vs_rise_s;
      $rose(i_vsync);
   endsequence
   irq_is_or_a: assert property (o_irq == (|o_pending)) else $error("irq mismatch");
   pend_hold_a: assert property (!$past(i_sys_rst) |->
      ((~o_pending & $past(o_pending) & ~$past(i_pend_clr)) == '0)) else $error("flag lost");
   link_stat_a: assert property (!$past(i_sys_rst) |->
      o_link_status == $past(i_link_clk_stable)) else $error("link status");
   link_up_a: assert property ($rose(o_link_status) |-> ##[0:1] o_pending[EV_LINK_UP]) else $error("up");
   link_dn_a: assert property ($fell(o_link_status) |-> ##[0:1] o_pending[EV_LINK_DOWN]) else $error("dn");
   frame_sync_a: assert property (vs_rise_s |=> o_pending[EV_FRAME_SYNC]) else $error("vsync");
   unlock_ev_a: assert property ($fell(i_bridge_locked) |=> o_pending[EV_BRIDGE_UNLOCK]) else $error("ul");
   cp14_gate_a: assert property ($rose(i_cp14_irq) |=> o_pending[EV_CP14] == P_CP14_EN) else $error("cp14");
   cp23_gate_a: assert property ($rose(i_cp23_timer_irq) |=>
      o_pending[EV_CP23_TIMER] == P_CP23_EN) else $error("cp23");
   // Event register then pending flag: two edges past the limit sample
   disc_time_a: assert property ($rose(o_pending[EV_DISCONNECT]) |->
      lo_cnt_r == P_HPD_DISC_CYC + 2) else $error("disconnect timing");
   hp_level_a: assert property (!$past(i_sys_rst) |->
      o_hot_plug_level == $past(i_hot_plug_sense)) else $error("hot plug level");
endmodule : tei_monitor

// file: tb/tei_sink_model.sv
`timescale 1ns/1ns
module tei_sink_model (
   input wire logic i_clk,
   output logic o_hot_plug_sense,
   output logic o_link_clk_stable
);
   initial begin
      o_hot_plug_sense = 1'b1;
      o_link_clk_stable = 1'b0;
   end
   // Sink holds a clean level; no bounce modelled
   task automatic hold(input logic lvl, input int n);
      @(negedge i_clk) o_hot_plug_sense = lvl;
      repeat (n) @(negedge i_clk);
   endtask : hold
   task automatic link(input logic st);
      @(negedge i_clk) o_link_clk_stable = st;
   endtask : link
endmodule : tei_sink_model

// file: tb/tei_top_tb_top.sv
`timescale 1ns/1ns
module tei_top_tb_top;
   import tei_pkg::*;
   // Short hot-plug windows keep the run small
   localparam int unsigned T_CONN = 20;
   localparam int unsigned T_DISC = 200;
   localparam int unsigned T_TMIN = 100;
   localparam int unsigned T_TMAX = 198;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [4:0] src = 5'h0;
   tei_ev_t clr = 10'h000;
   logic [EV_N-1:0] pend;
   logic hp, lcs, lst, irq, hpl;
   int n_fail = 0;
   int n_tests = 0;
   always #25 i_clk = ~i_clk;
   tei_sink_model i_tei_sink_model (.i_clk(i_clk), .o_hot_plug_sense(hp), .o_link_clk_stable(lcs));
   tei_top #(.P_HPD_CONN_CYC(T_CONN), .P_HPD_DISC_CYC(T_DISC), .P_HPD_TGL_MIN_CYC(T_TMIN),
      .P_HPD_TGL_MAX_CYC(T_TMAX)) i_tei_top (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hot_plug_sense(hp), .i_link_clk_stable(lcs), .i_vsync(src[0]),
      .i_bridge_locked(!src[1]), .i_cp14_irq(src[2]), .i_cp14_timer_irq(src[3]), .i_cp23_timer_irq(src[4]),
      .i_pend_clr(clr), .o_pending(pend), .o_link_status(lst), .o_hot_plug_level(hpl), .o_irq(irq));
   task automatic chk_vec(input tei_ev_t got, input tei_ev_t exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_vec
   task automatic chk_bit(input logic got, input logic exp);
      chk_vec(tei_ev_t'(got), tei_ev_t'(exp));
   endtask : chk_bit
   task automatic clr_all;
      @(negedge i_clk) clr = 10'h3ff;
      @(negedge i_clk) clr = 10'h000;
      repeat (2) @(negedge i_clk);
   endtask : clr_all
   task automatic summarize;
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // Low pulse of w sampled cycles, then high again
   task automatic pulse(input int unsigned w, input tei_ev_t exp);
      i_tei_sink_model.hold(1'b0, int'(w) - 1);
      i_tei_sink_model.hold(1'b1, 5);
      chk_vec(pend, exp);
      clr_all();
   endtask : pulse
   task automatic t_hot_plug;
      i_tei_sink_model.hold(1'b1, 2 * T_CONN);
      chk_vec(pend, 10'h000);
      chk_bit(hpl, 1'b1);
      i_tei_sink_model.hold(1'b0, T_DISC + 50);
      chk_vec(pend, 10'h002);
      chk_bit(hpl, 1'b0);
      clr_all();
      i_tei_sink_model.hold(1'b1, 2 * T_CONN);
      chk_vec(pend, 10'h001);
      clr_all();
      pulse(T_TMIN, 10'h004);
      pulse(T_TMAX, 10'h004);
      pulse(T_TMIN - 1, 10'h000);
      pulse(T_TMAX + 1, 10'h000);
   endtask : t_hot_plug
   task automatic t_link;
      i_tei_sink_model.link(1'b1);
      repeat (3) @(negedge i_clk);
      chk_bit(lst, 1'b1);
      chk_vec(pend, 10'h008);
      clr_all();
      i_tei_sink_model.link(1'b0);
      repeat (3) @(negedge i_clk);
      chk_bit(lst, 1'b0);
      chk_vec(pend, 10'h010);
      clr_all();
   endtask : t_link
   // Mid-run reset after a disconnect: flags drop and the disconnect history is forgotten
   task automatic t_reset;
      i_tei_sink_model.hold(1'b0, T_DISC + 50);
      chk_vec(pend, 10'h002);
      chk_bit(irq, 1'b1);
      i_sys_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      chk_vec(pend, 10'h000);
      chk_bit(irq, 1'b0);
      i_sys_rst = 1'b0;
      i_tei_sink_model.hold(1'b1, 2 * T_CONN);
      chk_vec(pend, 10'h000);
      chk_bit(hpl, 1'b1);
   endtask : t_reset
   task automatic t_sources;
      for (int k = 0; k < 5; k++) begin
         @(negedge i_clk) src[k] = 1'b1;
         repeat (2) @(negedge i_clk);
         chk_vec(pend, tei_ev_t'(1) << (EV_FRAME_SYNC + k));
         chk_bit(irq, 1'b1);
         clr_all();
         chk_bit(irq, 1'b0);
         src[k] = 1'b0;
      end
   endtask : t_sources
   initial begin
      repeat (16) @(negedge i_clk);
      i_sys_rst = 1'b0;
      t_hot_plug();
      t_link();
      t_sources();
      t_reset();
      summarize();
   end
   initial begin
      #(50 * 5000);
      n_fail++;
      summarize();
   end
endmodule : tei_top_tb_top
bind tei_top tei_monitor #(.P_HPD_DISC_CYC(P_HPD_DISC_CYC), .P_CP14_EN(P_CP14_EN), .P_CP23_EN(P_CP23_EN))
   i_tei_monitor (.i_clk, .i_sys_rst, .i_hot_plug_sense, .i_link_clk_stable, .i_vsync, .i_bridge_locked,
   .i_cp14_irq, .i_cp23_timer_irq, .i_pend_clr, .o_pending, .o_link_status, .o_hot_plug_level, .o_irq);
